/* verilog/prp_profiler.sv */
// Position reference profiler: two-step linear ramps, exponential or
// moving average smoothing, and positioning-completed status.
// Assumes parameter writes and commands synchronous to clk_sys.
`timescale 1ns/1ps
module prp_profiler
    import prp_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Parameter link
    input wire logic prmWrEn,
    input wire logic [3:0] prmIdx,
    input wire logic [31:0] prmWrData,
    input wire logic [3:0] prmRdIdx,
    output logic [31:0] prmRdData,
    output logic prmReject,
    // Motion command
    input wire logic cmdStart,
    input wire logic signed [31:0] cmdTarget,
    input wire logic [31:0] cmdSpeed,
    output logic cmdReady,
    // Feedback and status
    input wire logic signed [31:0] feedbackPos,
    output logic signed [31:0] refPos,
    output logic distComplete,
    output logic posCompleteFlag,
    output logic coincidenceOut
);

    typedef struct packed {
        prp_state_t st;
        logic [31:0] tick;
        logic [8:0][15:0] wPrm;
        logic [8:0][15:0] aPrm;
        logic [31:0] width;
        logic [31:0] rdData;
        logic reject;
        logic signed [47:0] xP;
        logic [47:0] rem;
        logic [31:0] v;
        logic [31:0] vMax;
        logic dir;
        logic profDone;
        logic signed [31:0] delta;
        logic signed [47:0] y;
        logic signed [47:0] sum;
        logic signed [47:0] maRem;
        logic signed [47:0] outRem;
        logic [MA_AW-1:0] fill;
        logic [MA_AW-1:0] wp;
        prp_div_t div;
        logic signed [31:0] refPos;
        logic signed [31:0] tgt;
        logic done;
        logic flag;
        logic match;
    } prp_reg_t;

    prp_reg_t q, d;
    logic memWe;
    logic [MA_AW-1:0] memRa;
    logic signed [31:0] memRd;
    logic [15:0] accRate, decRate, dBrk;
    logic brake;
    logic [31:0] vAcc, vDec;
    logic [32:0] accSum;
    logic [71:0] brkLhs, brkRhs;
    logic signed [47:0] qs, rs;
    logic [32:0] posErr;

    function automatic logic [47:0] absV(input logic signed [47:0] x);
        return x[47] ? 48'(-x) : 48'(x);
    endfunction

    function automatic logic [32:0] swSpeed(input logic [15:0] s,
                                            input logic [15:0] unit);
        return 33'(s) * 33'(unit);
    endfunction

    function automatic prp_div_t divStart(input logic signed [47:0] n,
                                          input logic [15:0] dvsr,
                                          input logic out);
        prp_div_t r;
        r.num = absV(n);
        r.r = 16'h0000;
        r.dvsr = dvsr;
        r.cnt = 6'h00;
        r.neg = n[47];
        r.out = out;
        return r;
    endfunction

    function automatic logic valueOk(input logic [3:0] idx,
                                     input logic [31:0] val);
        logic ok;
        ok = 1'b0;
        if (idx == IDX_ACC1 || idx == IDX_ACC2 || idx == IDX_DEC1 ||
            idx == IDX_DEC2) begin
            ok = val != 32'h0 && val <= MAX_RATE;
        end else if (idx == IDX_ACC_SW || idx == IDX_DEC_SW) begin
            ok = val <= MAX_RATE;
        end else if (idx == IDX_BIAS) begin
            ok = val <= MAX_BIAS;
        end else if (idx == IDX_EXPT || idx == IDX_MAVG) begin
            ok = val <= MAX_TIME;
        end
        return ok;
    endfunction

    // Stage selection from the live speed
    assign accRate = (q.aPrm[IDX_ACC_SW] == 16'h0 ||
        {1'b0, q.v} >= swSpeed(q.aPrm[IDX_ACC_SW], ACC_SW_UNIT)) ?
        q.aPrm[IDX_ACC2] : q.aPrm[IDX_ACC1];
    assign decRate = (q.aPrm[IDX_DEC_SW] == 16'h0 ||
        {1'b0, q.v} >= swSpeed(q.aPrm[IDX_DEC_SW], DEC_SW_UNIT)) ?
        q.aPrm[IDX_DEC2] : q.aPrm[IDX_DEC1];
    // Braking distance uses the gentler stage so the stop is never late
    assign dBrk = (q.aPrm[IDX_DEC_SW] == 16'h0 ||
        q.aPrm[IDX_DEC1] > q.aPrm[IDX_DEC2]) ?
        q.aPrm[IDX_DEC2] : q.aPrm[IDX_DEC1];
    assign brkLhs = 72'(q.rem) * 72'({dBrk, 1'b0});
    assign brkRhs = 72'(q.v) * 72'(33'(q.v) + 33'(dBrk));
    assign brake = brkLhs <= brkRhs;
    assign accSum = 33'(q.v) + 33'(accRate);
    assign vAcc = (accSum >= {1'b0, q.vMax}) ? q.vMax : accSum[31:0];
    // Speed floors at the braking rate so an early stop still creeps in
    assign vDec = ({1'b0, q.v} >= 33'(decRate) + 33'(dBrk)) ?
        q.v - 32'(decRate) : 32'(dBrk);
    // Signed divider results
    assign qs = q.div.neg ? -$signed(q.div.num) : $signed(q.div.num);
    assign rs = q.div.neg ? -$signed(48'(q.div.r)) : $signed(48'(q.div.r));
    assign posErr = 33'(q.tgt) - 33'(feedbackPos);

    // Next-state logic for the whole block
    always_comb begin
        logic [31:0] vNext;
        logic [47:0] step;
        logic signed [47:0] stepS, err, tgtS, sNew, old;
        logic [47:0] mag;
        logic [16:0] rSh;
        logic [32:0] errMag;
        vNext = 32'h0;
        step = 48'h0;
        stepS = 48'sh0;
        err = q.xP - q.y;
        tgtS = $signed(48'(cmdTarget) * 48'(POS_SCALE));
        sNew = 48'sh0;
        old = 48'sh0;
        mag = 48'h0;
        rSh = {q.div.r, q.div.num[47]};
        errMag = posErr[32] ? 33'(-posErr) : posErr;
        d = q;
        d.reject = 1'b0;
        memWe = 1'b0;
        memRa = q.wp - q.aPrm[IDX_MAVG][MA_AW-1:0];
        // Parameter writes from the link, bad index or value refused
        if (prmWrEn) begin
            if (prmIdx == IDX_WIDTH && prmWrData <= MAX_WIDTH) begin
                d.width = prmWrData;
            end else if (prmIdx < IDX_WIDTH && valueOk(prmIdx, prmWrData)) begin
                d.wPrm[prmIdx] = prmWrData[15:0];
            end else begin
                d.reject = 1'b1;
            end
        end
        // Registered read-back
        if (prmRdIdx == IDX_WIDTH) begin
            d.rdData = q.width;
        end else if (prmRdIdx == IDX_STATUS) begin
            d.rdData = 32'h0;
            d.rdData[ST_DONE_BIT] = q.done;
            d.rdData[ST_FLAG_BIT] = q.flag;
            d.rdData[ST_MATCH_BIT] = q.match;
        end else if (prmRdIdx < IDX_WIDTH) begin
            d.rdData = {16'h0000, q.wPrm[prmRdIdx]};
        end else begin
            d.rdData = 32'h0;
        end
        // Profile settings follow the written copy only while at rest
        if (q.done) begin
            d.aPrm = q.wPrm;
            if (q.wPrm[IDX_MAVG] != q.aPrm[IDX_MAVG]) begin
                d.fill = '0;
            end
        end
        case (q.st)
            ST_WAIT: begin
                d.tick = q.tick + 32'h1;
                if (cmdStart && q.done) begin
                    d.tgt = cmdTarget;
                    d.dir = tgtS < q.xP;
                    d.rem = absV(tgtS - q.xP);
                    d.profDone = tgtS == q.xP;
                    d.done = tgtS == q.xP;
                    d.v = 32'h0;
                    d.vMax = (cmdSpeed[30:0] == 31'h0) ? 32'h1 :
                        {1'b0, cmdSpeed[30:0]};
                end
                if (q.tick >= 32'(TICK_LEN - 1)) begin
                    d.tick = 32'h0;
                    d.st = ST_PROF;
                end
            end
            ST_PROF: begin
                d.delta = 32'sh0;
                if (!q.profDone) begin
                    vNext = brake ? vDec : vAcc;
                    if (48'(vNext) >= q.rem) begin
                        step = q.rem;
                        d.profDone = 1'b1;
                        d.v = 32'h0;
                    end else begin
                        step = 48'(vNext);
                        d.v = vNext;
                    end
                    d.rem = q.rem - step;
                    stepS = q.dir ? -$signed(step) : $signed(step);
                    d.xP = q.xP + stepS;
                    d.delta = 32'(stepS);
                end
                memWe = 1'b1;
                d.wp = q.wp + 1'b1;
                d.st = ST_FILT;
            end
            ST_FILT: begin
                // Selected smoothing, none when both times are zero
                if (q.aPrm[IDX_MAVG] != 16'h0) begin
                    if (q.fill >= q.aPrm[IDX_MAVG][MA_AW-1:0]) begin
                        old = 48'(memRd);
                    end else begin
                        d.fill = q.fill + 1'b1;
                    end
                    sNew = q.sum + 48'(q.delta) - old;
                    d.sum = sNew;
                    d.div = divStart(sNew + q.maRem, q.aPrm[IDX_MAVG], 1'b0);
                end else if (q.aPrm[IDX_EXPT] != 16'h0) begin
                    d.div = divStart(err, q.aPrm[IDX_EXPT], 1'b0);
                end else begin
                    d.y = q.xP;
                    d.div = divStart(err + q.outRem, POS_SCALE, 1'b1);
                end
                d.st = ST_DIV;
            end
            ST_DIV: begin
                // One quotient bit per cycle, restoring
                if (rSh >= {1'b0, q.div.dvsr}) begin
                    rSh = rSh - {1'b0, q.div.dvsr};
                    d.div.num = {q.div.num[46:0], 1'b1};
                end else begin
                    d.div.num = {q.div.num[46:0], 1'b0};
                end
                d.div.r = rSh[15:0];
                d.div.cnt = q.div.cnt + 6'h1;
                if (q.div.cnt == DIV_LAST) begin
                    d.st = q.div.out ? ST_OUT : ST_MIX;
                end
            end
            ST_MIX: begin
                if (q.aPrm[IDX_MAVG] != 16'h0) begin
                    stepS = qs;
                    d.maRem = rs;
                end else begin
                    // Bias adds a fixed speed; a stuck quotient still moves
                    mag = absV(qs);
                    if (mag == 48'h0 && err != 48'sh0) begin
                        mag = 48'h1;
                    end
                    mag = mag + 48'(q.aPrm[IDX_BIAS]);
                    if (mag > absV(err)) begin
                        mag = absV(err);
                    end
                    stepS = err[47] ? -$signed(mag) : $signed(mag);
                end
                d.y = q.y + stepS;
                d.div = divStart(stepS + q.outRem, POS_SCALE, 1'b1);
                d.st = ST_DIV;
            end
            ST_OUT: begin
                // Whole reference units out, fraction carried forward
                d.refPos = q.refPos + 32'(qs);
                d.outRem = rs;
                d.done = q.profDone && q.y == q.xP && q.sum == 48'sh0 &&
                    q.maRem == 48'sh0 && rs == 48'sh0;
                d.st = ST_WAIT;
            end
            default: begin
                d.st = ST_WAIT;
            end
        endcase
        // Width applies at once, shared by flag and coincidence pin
        d.match = errMag <= 33'(d.width);
        d.flag = d.match && d.done;
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= ST_WAIT;
            q.wPrm <= PRM_RESET;
            q.aPrm <= PRM_RESET;
            q.width <= RST_WIDTH;
            q.done <= 1'b1;
            q.profDone <= 1'b1;
            q.vMax <= 32'h1;
        end else begin
            q <= d;
        end
    end

    prp_sample_ram u_ram (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wrEn(memWe),
        .wrAddr(q.wp),
        .wrData(d.delta),
        .rdAddr(memRa),
        .rdData(memRd)
    );

    // Outputs
    assign prmRdData = q.rdData;
    assign prmReject = q.reject;
    assign cmdReady = q.done && q.st == ST_WAIT;
    assign refPos = q.refPos;
    assign distComplete = q.done;
    assign posCompleteFlag = q.flag;
    assign coincidenceOut = q.match;

    // Position error magnitude seen by the width checks
    logic [32:0] errMagD;
    assign errMagD = posErr[32] ? 33'(-posErr) : posErr;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_ACC1_HELD: assert property (
        !distComplete |=> $stable(q.aPrm[IDX_ACC1]))
        else $error("first accel rate changed during motion");
    AST_ACC2_SINGLE: assert property (
        q.st == ST_PROF && !q.profDone && !brake &&
        q.aPrm[IDX_ACC_SW] == 16'h0 && accSum < {1'b0, q.vMax} &&
        q.rem > 48'(accSum) |=> q.v == $past(q.v) + 32'($past(q.aPrm[IDX_ACC2])))
        else $error("single-step accel not using second rate");
    AST_ACC_SWITCH: assert property (
        q.st == ST_PROF && q.aPrm[IDX_ACC_SW] != 16'h0 &&
        {1'b0, q.v} < swSpeed(q.aPrm[IDX_ACC_SW], ACC_SW_UNIT) |->
        accRate == q.aPrm[IDX_ACC1])
        else $error("first accel rate not used below switch speed");
    AST_DEC1_HELD: assert property (
        $rose(q.st == ST_PROF) && !distComplete && $past(!distComplete) |->
        $stable(q.aPrm[IDX_DEC1]))
        else $error("first decel rate changed during motion");
    AST_DEC2_SINGLE: assert property (
        q.st == ST_PROF && !q.profDone && brake &&
        q.aPrm[IDX_DEC_SW] == 16'h0 && q.rem > 48'(q.v) &&
        {1'b0, q.v} >= 33'(q.aPrm[IDX_DEC2]) + 33'(dBrk) |=>
        q.v == $past(q.v) - 32'($past(q.aPrm[IDX_DEC2])))
        else $error("single-step decel not using second rate");
    AST_DEC_SWITCH: assert property (
        q.st == ST_PROF && q.aPrm[IDX_DEC_SW] != 16'h0 &&
        {1'b0, q.v} >= 33'(q.aPrm[IDX_DEC_SW]) * 33'(DEC_SW_UNIT) |->
        decRate == q.aPrm[IDX_DEC2])
        else $error("second decel rate not used above switch speed");
    AST_FILT_HELD: assert property (
        !distComplete [*2] |-> $stable(q.aPrm[IDX_BIAS]) &&
        $stable(q.aPrm[IDX_EXPT]))
        else $error("filter settings changed during motion");
    AST_POSITIONING_COMPLETED_FLAG_DONE: assert property (
        posCompleteFlag |-> distComplete && coincidenceOut)
        else $error("completed flag without done and width");
    AST_WIDTH_NOW: assert property (
        $past(rst_n) |->
        coincidenceOut == ($past(errMagD) <= 33'($past(d.width))))
        else $error("coincidence not using current width");
    AST_WIDTH_WRITE: assert property (
        prmWrEn && prmIdx == IDX_WIDTH && prmWrData <= MAX_WIDTH |=>
        q.width == $past(prmWrData) && !prmReject)
        else $error("width write not accepted");
    AST_BYPASS: assert property (
        q.st == ST_FILT && q.aPrm[IDX_MAVG] == 16'h0 &&
        q.aPrm[IDX_EXPT] == 16'h0 |=> q.y == $past(q.xP))
        else $error("unfiltered reference not passed straight");

    COV_MOVE_DONE: cover property ($rose(distComplete));
    COV_POSITIONING_COMPLETED_FLAG: cover property ($rose(posCompleteFlag));
    COV_TWO_STEP: cover property (q.st == ST_PROF &&
        q.aPrm[IDX_ACC_SW] != 16'h0 && accRate == q.aPrm[IDX_ACC2]);
    COV_REJECT: cover property (prmReject);

endmodule

/* verilog/prp_pkg.sv */
// Constants and types shared by the position reference profiler.
// Assumes a 200 MHz system clock and a 0.1 ms profile update tick.
package prp_pkg;

    // Clock and tick timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TICK_TIME_PS = 100000000;
    localparam int TICK_CYCLES = TICK_TIME_PS / CLK_PERIOD_PS;

    // Parameter link indices
    localparam logic [3:0] IDX_ACC1 = 4'h0;
    localparam logic [3:0] IDX_ACC2 = 4'h1;
    localparam logic [3:0] IDX_ACC_SW = 4'h2;
    localparam logic [3:0] IDX_DEC1 = 4'h3;
    localparam logic [3:0] IDX_DEC2 = 4'h4;
    localparam logic [3:0] IDX_DEC_SW = 4'h5;
    localparam logic [3:0] IDX_BIAS = 4'h6;
    localparam logic [3:0] IDX_EXPT = 4'h7;
    localparam logic [3:0] IDX_MAVG = 4'h8;
    localparam logic [3:0] IDX_WIDTH = 4'h9;
    localparam logic [3:0] IDX_STATUS = 4'ha;

    // Status word bit positions
    localparam int ST_DONE_BIT = 0;
    localparam int ST_FLAG_BIT = 1;
    localparam int ST_MATCH_BIT = 2;

    // Reset values
    localparam logic [15:0] RST_RATE = 16'h0064;
    localparam logic [15:0] RST_SWITCH = 16'h0000;
    localparam logic [15:0] RST_BIAS = 16'h0000;
    localparam logic [15:0] RST_TIME = 16'h0000;
    localparam logic [31:0] RST_WIDTH = 32'h00000007;
    localparam logic [8:0][15:0] PRM_RESET = {RST_TIME, RST_TIME, RST_BIAS,
        RST_SWITCH, RST_RATE, RST_RATE, RST_SWITCH, RST_RATE, RST_RATE};

    // Accepted ranges
    localparam logic [31:0] MAX_RATE = 32'h0000ffff;
    localparam logic [31:0] MAX_BIAS = 32'h00007fff;
    localparam logic [31:0] MAX_TIME = 32'h000013ec;
    localparam logic [31:0] MAX_WIDTH = 32'h40000000;

    // Units: speeds in ref units/s, positions in 1/10000 ref unit
    localparam logic [15:0] ACC_SW_UNIT = 16'h2710;
    localparam logic [15:0] DEC_SW_UNIT = 16'h0064;
    localparam logic [15:0] POS_SCALE = 16'h2710;

    // Moving average window memory and divider length
    localparam int MA_AW = 13;
    localparam int DIV_BITS = 48;
    localparam logic [5:0] DIV_LAST = 6'h2f;

    typedef enum logic [2:0] {
        ST_WAIT, ST_PROF, ST_FILT, ST_DIV, ST_MIX, ST_OUT
    } prp_state_t;

    typedef struct packed {
        logic [47:0] num;
        logic [15:0] r;
        logic [15:0] dvsr;
        logic [5:0] cnt;
        logic neg;
        logic out;
    } prp_div_t;

endpackage

/* verilog/prp_sample_ram.sv */
// Sample memory holding the moving average window of reference steps.
// Assumes one write and one read per cycle; read data is registered.
`timescale 1ns/1ps
module prp_sample_ram
    import prp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Write side
    input wire logic wrEn,
    input wire logic [MA_AW-1:0] wrAddr,
    input wire logic signed [31:0] wrData,
    // Read side
    input wire logic [MA_AW-1:0] rdAddr,
    output logic signed [31:0] rdData
);

    logic signed [31:0] mem [0:(1<<MA_AW)-1];

    // Array left without reset so it can map onto block RAM
    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // Read data registered; reads of the write address return old data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdData <= 32'sh00000000;
        end else begin
            rdData <= mem[rdAddr];
        end
    end

endmodule

/* bench/prp_host_model.sv */
// Host controller model: writes profile settings and starts moves.
// Assumes the bench calls its tasks at a time just after a rising edge.
`timescale 1ns/1ps
module prp_host_model (
    // Clock
    input wire logic clk_sys,
    // Parameter link
    output logic prmWrEn,
    output logic [3:0] prmIdx,
    output logic [31:0] prmWrData,
    // Motion command
    output logic cmdStart,
    output logic signed [31:0] cmdTarget,
    output logic [31:0] cmdSpeed,
    input wire logic cmdReady
);
    // Idle link at time zero
    initial begin
        prmWrEn = 1'b0;
        prmIdx = 4'h0;
        prmWrData = 32'h0;
        cmdStart = 1'b0;
        cmdTarget = 32'sh0;
        cmdSpeed = 32'h1;
    end
    // One-cycle write strobe; data inverted after so stale values never match
    task automatic put(input logic [3:0] idx, input logic [31:0] val);
        @(posedge clk_sys);
        #1;
        prmWrEn = 1'b1;
        prmIdx = idx;
        prmWrData = val;
        @(posedge clk_sys);
        #1;
        prmWrEn = 1'b0;
        prmWrData = ~val;
    endtask
    // Move start pulse, held back until the device shows ready
    task automatic go(input logic signed [31:0] tgt, input logic [31:0] spd);
        @(posedge clk_sys);
        #1;
        while (cmdReady !== 1'b1) begin
            @(posedge clk_sys);
            #1;
        end
        cmdStart = 1'b1;
        cmdTarget = tgt;
        cmdSpeed = spd;
        @(posedge clk_sys);
        #1;
        cmdStart = 1'b0;
        cmdTarget = ~tgt;
    endtask
endmodule

/* bench/prp_profiler_bench.sv */
// Self-checking bench for the position reference profiler.
// Assumes a 200-cycle profile tick so each move ends in under 60000 cycles.
`timescale 1ns/1ps
module prp_profiler_bench;
    import prp_pkg::*;
    logic clk_sys, rst_n, prmWrEn, prmReject, cmdStart, cmdReady;
    logic [3:0] prmIdx, prmRdIdx;
    logic [31:0] prmWrData, prmRdData, cmdSpeed;
    logic signed [31:0] cmdTarget, feedbackPos, refPos;
    logic distComplete, posCompleteFlag, coincidenceOut;
    int n_errors, checks;
    logic [31:0] mirror [0:9];
    // Write table: index, value, refused; boundaries on both sides
    logic [3:0] wIdx [0:10] = '{4'h0, 4'h0, 4'h2, 4'h6, 4'h6, 4'h7, 4'h8,
        4'h8, 4'h9, 4'ha, 4'h9};
    logic [31:0] wVal [0:10] = '{32'h0, 32'hffff, 32'h10000, 32'h8000,
        32'h7fff, 32'h13ed, 32'h13ec, 32'h14, 32'h40000001, 32'h1, 32'h40000000};
    logic wBad [0:10] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0,
        1'b1, 1'b1, 1'b0};

    prp_profiler #(.TICK_LEN(200)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .prmWrEn(prmWrEn), .prmIdx(prmIdx), .prmWrData(prmWrData),
        .prmRdIdx(prmRdIdx), .prmRdData(prmRdData), .prmReject(prmReject),
        .cmdStart(cmdStart), .cmdTarget(cmdTarget), .cmdSpeed(cmdSpeed),
        .cmdReady(cmdReady), .feedbackPos(feedbackPos), .refPos(refPos),
        .distComplete(distComplete), .posCompleteFlag(posCompleteFlag),
        .coincidenceOut(coincidenceOut));
    prp_host_model host (.clk_sys(clk_sys), .prmWrEn(prmWrEn),
        .prmIdx(prmIdx), .prmWrData(prmWrData), .cmdStart(cmdStart),
        .cmdTarget(cmdTarget), .cmdSpeed(cmdSpeed), .cmdReady(cmdReady));

    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Readback lags the index by one edge; the task waits two
    task automatic rd(input logic [3:0] idx, output logic [31:0] val);
        @(posedge clk_sys);
        #1;
        prmRdIdx = idx;
        repeat (2) @(posedge clk_sys);
        #1;
        val = prmRdData;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_reset;
        logic [31:0] v;
        for (int i = 0; i < 10; i++) begin
            rd(i[3:0], v);
            chk("reset value", mirror[i], v);
        end
        $display("test reset values done");
    endtask
    // Range limits: refused writes pulse reject and leave the value alone
    task automatic t_limits;
        logic [31:0] v;
        for (int i = 0; i < 11; i++) begin
            host.put(wIdx[i], wVal[i]);
            chk("reject", {31'h0, wBad[i]}, {31'h0, prmReject});
            if (!wBad[i]) mirror[wIdx[i]] = wVal[i];
            if (wIdx[i] < IDX_STATUS) begin
                rd(wIdx[i], v);
                chk("readback", mirror[wIdx[i]], v);
            end
        end
        $display("test limits done");
    endtask
    // Width change acts at once on both flag and coincidence output
    task automatic t_width;
        logic [31:0] v;
        feedbackPos = 32'sh3;
        host.put(IDX_WIDTH, 32'h2);
        @(posedge clk_sys);
        #1;
        chk("coincidenceOut", 32'h0, {31'h0, coincidenceOut});
        chk("flag", 32'h0, {31'h0, posCompleteFlag});
        host.put(IDX_WIDTH, 32'h3);
        @(posedge clk_sys);
        #1;
        chk("flag", 32'h1, {31'h0, posCompleteFlag});
        rd(IDX_STATUS, v);
        chk("status", 32'h7, v);
        $display("test width done");
    endtask
    // Move with feedback already at target: flag waits for distribution
    task automatic t_move(input logic signed [31:0] tgt);
        int n;
        feedbackPos = tgt;
        host.go(tgt, 32'h3e8);
        chk("done", 32'h0, {31'h0, distComplete});
        chk("cmdReady", 32'h0, {31'h0, cmdReady});
        @(posedge clk_sys);
        #1;
        chk("flag", 32'h0, {31'h0, posCompleteFlag});
        chk("coincidenceOut", 32'h1, {31'h0, coincidenceOut});
        n = 0;
        while (distComplete !== 1'b1 && n < 60000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("done", 32'h1, {31'h0, distComplete});
        chk("refPos", tgt, refPos);
        chk("flag", 32'h1, {31'h0, posCompleteFlag});
        $display("test move done");
    endtask

    // Main sequence; reset held 12 cycles
    initial begin
        rst_n = 1'b0;
        prmRdIdx = 4'h0;
        feedbackPos = 32'sh0;
        n_errors = 0;
        checks = 0;
        mirror = '{32'h64, 32'h64, 32'h0, 32'h64, 32'h64, 32'h0, 32'h0,
            32'h0, 32'h0, 32'h7};
        repeat (12) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_reset;
        t_limits;
        t_width;
        t_move(32'sh5);
        host.put(IDX_MAVG, 32'h0);
        host.put(IDX_EXPT, 32'ha);
        host.put(IDX_BIAS, 32'h32);
        host.put(IDX_ACC_SW, 32'h1);
        host.put(IDX_DEC_SW, 32'h5);
        t_move(-32'sh3);
        conclude;
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_errors++;
        conclude;
    end
endmodule
